// ==== design/pwt_pkg.sv ====
// Package with the register map, field layout and reset values of the periodic wakeup timer.
package pwt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus geometry.
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [1:0] OFS_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] OFS_PRESCALE       = 2'h1;
  localparam logic [1:0] OFS_MODULO         = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Bit positions inside the status and control register.
  localparam int unsigned BIT_ENABLE    = 0;
  localparam int unsigned BIT_CLK_SEL   = 1;
  localparam int unsigned BIT_FLAG      = 2;
  localparam int unsigned BIT_ACK       = 3;
  localparam int unsigned BIT_IRQ_EN    = 4;
  localparam int unsigned BIT_STOP_RUN  = 5;

  // Prescale code field.
  localparam int unsigned PRESCALE_W    = 4;
  localparam int unsigned PRESCALE_LSB  = 0;

  // Prescaler depth: code 1111 divides by 32768, so fifteen divider bits.
  localparam int unsigned DIV_W         = 15;

  // Counter and modulo width.
  localparam int unsigned COUNT_W       = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [PRESCALE_W-1:0] RST_PRESCALE = 4'h0;
  localparam logic [COUNT_W-1:0]    RST_MODULO   = 8'h00;
  localparam logic [COUNT_W-1:0]    RST_COUNT    = 8'h00;
  localparam logic [DATA_W-1:0]     RST_RDATA    = 8'h00;

  // Nominal rate of the RC oscillator source clock.
  localparam int unsigned RC_OSC_KHZ = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // Control fields that software owns.
  typedef struct packed {
    logic                  enable;
    logic                  clk_sel;
    logic                  irq_en;
    logic                  stop_run;
    logic [PRESCALE_W-1:0] prescale;
    logic [COUNT_W-1:0]    modulo;
  } pwt_ctrl_t;

  // Register bus request.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pwt_bus_req_t;

endpackage

// ==== design/pwt_prescaler.sv ====
// Clock source selection and power-of-two prescaler of the periodic wakeup timer.
`timescale 1ns/100ps
module pwt_prescaler (
  input  wire logic                             clk,
  input  wire logic                             resetn,
  input  wire logic                             run,
  input  wire logic                             clk_sel,
  input  wire logic [pwt_pkg::PRESCALE_W-1:0]   prescale,
  input  wire logic                             rc_osc_tick,
  input  wire logic                             fast_bus_tick,
  output logic                                  counter_tick_ff
);

  logic [pwt_pkg::DIV_W-1:0] div_ff;
  logic [pwt_pkg::DIV_W-1:0] div_mask;
  logic                      src_tick;
  logic                      div_full;

  ////////////////////////////////////////////////////////////////////////////////
  // Choose the fast bus clock when set, else the RC oscillator.
  assign src_tick = clk_sel ? fast_bus_tick : rc_osc_tick;

  // Build a mask with the low prescale-code bits set, one bit per stage.
  genvar gi;
  generate
    for (gi = 0; gi < pwt_pkg::DIV_W; gi++) begin : g_mask
      assign div_mask[gi] = (gi < prescale);
    end
  endgenerate

  // The divider is full when every masked bit is one.
  assign div_full = ((div_ff & div_mask) == div_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // Divider counts source ticks and is held clear while not running.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= '0;
    end else if (!run) begin
      div_ff <= '0;
    end else if (src_tick) begin
      div_ff <= div_full ? '0 : div_ff + 1'b1;
    end
  end

  // One counter tick every two-to-the-code source ticks.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      counter_tick_ff <= 1'b0;
    end else begin
      counter_tick_ff <= run & src_tick & div_full;
    end
  end

endmodule // pwt_prescaler

// ==== design/pwt_counter.sv ====
// Modulo counter of the periodic wakeup timer.
`timescale 1ns/100ps
module pwt_counter (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          run,
  input  wire logic                          tick,
  input  wire logic [pwt_pkg::COUNT_W-1:0]   modulo,
  output logic [pwt_pkg::COUNT_W-1:0]        count_ff,
  output logic                               match_ff
);

  logic [pwt_pkg::COUNT_W-1:0] nxt_count;
  logic [pwt_pkg::COUNT_W-1:0] count_inc;
  logic                        wrap;

  ////////////////////////////////////////////////////////////////////////////////
  // Reaching the modulo value is the match and restarts the count from zero.
  // One period then spans exactly modulo ticks, so software can take the
  // product of prescaler period and modulo; a modulo of zero matches every tick.
  assign count_inc = count_ff + 1'b1;
  assign wrap      = (count_inc == modulo) | (modulo == pwt_pkg::RST_COUNT);

  // Next count: zero on the match tick, else one more.
  always_comb begin
    if (wrap) begin
      nxt_count = pwt_pkg::RST_COUNT;
    end else begin
      nxt_count = count_inc;
    end
  end

  // Counter is zeroed whenever the block is not running.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_ff <= pwt_pkg::RST_COUNT;
    end else if (!run) begin
      count_ff <= pwt_pkg::RST_COUNT;
    end else if (tick) begin
      count_ff <= nxt_count;
    end
  end

  // Match pulse when the counter arrives at the modulo value.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= run & tick & wrap;
    end
  end

endmodule // pwt_counter

// ==== design/pwt_timer.sv ====
// Top of the periodic wakeup timer: registers, flag, interrupt and low-power control.
//
// How it works
// - Enabled counter counts prescaled ticks to modulo, latches flag, restarts from zero.
// - Clock select set picks fast bus clock, clear picks the RC oscillator.
// - Prescale code divides the source clock by two to the code.
// - Clock select, prescale and modulo accept writes only while disabled.
// - Counter held at zero while disabled or stopped without stop-run.
// - Stop-run set keeps counting in stop mode; clear halts it there.
// - Flag is read-only; cleared by acknowledge write of one or vector fetch.
// - Acknowledge bit is write-only and always reads zero.
// - Interrupt request is high exactly while flag and interrupt enable are set.
// - Module keeps running in wait mode while enabled; request wakes processor.
// - With enable and stop-run set, runs in stop mode; request ends stop.
// - In break with clear-enable low the flag is protected from clearing.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module pwt_timer (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  input  wire logic [pwt_pkg::ADDR_W-1:0]    addr,
  input  wire logic [pwt_pkg::DATA_W-1:0]    wr_data,
  input  wire logic                          rc_osc_tick,
  input  wire logic                          fast_bus_tick,
  input  wire logic                          stop_mode,
  input  wire logic                          break_state,
  input  wire logic                          break_clear_enable,
  input  wire logic                          vector_fetch,
  output logic [pwt_pkg::DATA_W-1:0]         rd_data_ff,
  output logic                               wake_irq_request_ff,
  output logic                               wake_flag_ff
);

  pwt_pkg::pwt_ctrl_t           ctrl_ff;
  pwt_pkg::pwt_bus_req_t        req;
  logic                         run;
  logic                         tick;
  logic                         match;
  logic                         wr_sc;
  logic                         wr_ps;
  logic                         wr_mod;
  logic                         flag_clear;
  logic                         nxt_flag;
  logic [pwt_pkg::DATA_W-1:0]   nxt_rd_data;

  ////////////////////////////////////////////////////////////////////////////////
  // Bundle the bus request and decode the write targets.
  assign req = {wr_en, rd_en, addr, wr_data};

  assign wr_sc  = req.wr & (req.addr == pwt_pkg::OFS_STATUS_CONTROL);
  assign wr_ps  = req.wr & (req.addr == pwt_pkg::OFS_PRESCALE);
  assign wr_mod = req.wr & (req.addr == pwt_pkg::OFS_MODULO);

  ////////////////////////////////////////////////////////////////////////////////
  // The block runs when enabled, except in stop mode without stop-run.
  // Wait mode is not an input at all: the block simply keeps running.
  assign run = ctrl_ff.enable & ~(stop_mode & ~ctrl_ff.stop_run);

  // Source clock selection and prescaling.
  pwt_prescaler pwt_prescaler_inst (
    .clk             (clk),
    .resetn          (resetn),
    .run             (run),
    .clk_sel         (ctrl_ff.clk_sel),
    .prescale        (ctrl_ff.prescale),
    .rc_osc_tick     (rc_osc_tick),
    .fast_bus_tick   (fast_bus_tick),
    .counter_tick_ff (tick)
  );

  // Modulo counter that produces the match event.
  // The count itself is internal; only the match leaves the counter.
  pwt_counter pwt_counter_inst (
    .clk      (clk),
    .resetn   (resetn),
    .run      (run),
    .tick     (tick),
    .modulo   (ctrl_ff.modulo),
    .count_ff (),
    .match_ff (match)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // All control fields live in one process, so the struct has a single driver.
  // Enable, stop-run and interrupt enable are always writable. Clock select,
  // prescale and modulo take writes only while disabled: a write while enabled
  // is dropped with no error, so software must disable the timer to retune it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff.enable   <= 1'b0;
      ctrl_ff.irq_en   <= 1'b0;
      ctrl_ff.stop_run <= 1'b0;
      ctrl_ff.clk_sel  <= 1'b0;
      ctrl_ff.prescale <= pwt_pkg::RST_PRESCALE;
      ctrl_ff.modulo   <= pwt_pkg::RST_MODULO;
    end else begin
      if (wr_sc) begin
        ctrl_ff.enable   <= req.wdata[pwt_pkg::BIT_ENABLE];
        ctrl_ff.irq_en   <= req.wdata[pwt_pkg::BIT_IRQ_EN];
        ctrl_ff.stop_run <= req.wdata[pwt_pkg::BIT_STOP_RUN];
      end
      if (wr_sc && !ctrl_ff.enable) begin
        ctrl_ff.clk_sel <= req.wdata[pwt_pkg::BIT_CLK_SEL];
      end
      if (wr_ps && !ctrl_ff.enable) begin
        ctrl_ff.prescale <= req.wdata[pwt_pkg::PRESCALE_LSB +: pwt_pkg::PRESCALE_W];
      end
      if (wr_mod && !ctrl_ff.enable) begin
        ctrl_ff.modulo <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flag clears on acknowledge or vector fetch, unless protected by break.
  assign flag_clear = ((wr_sc & req.wdata[pwt_pkg::BIT_ACK]) | vector_fetch)
                    & ~(break_state & ~break_clear_enable);

  // A match in the same cycle as a clear wins, so no event is lost.
  assign nxt_flag = match | (wake_flag_ff & ~flag_clear);

  // Sticky wake flag.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_flag_ff <= 1'b0;
    end else begin
      wake_flag_ff <= nxt_flag;
    end
  end

  // Level request, masked by the interrupt enable, tracks the flag.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_irq_request_ff <= 1'b0;
    end else begin
      wake_irq_request_ff <= nxt_flag & (wr_sc ? req.wdata[pwt_pkg::BIT_IRQ_EN]
                                               : ctrl_ff.irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; the acknowledge bit and unused bits read as zero.
  always_comb begin
    nxt_rd_data = pwt_pkg::RST_RDATA;
    unique case (req.addr)
      pwt_pkg::OFS_STATUS_CONTROL: begin
        nxt_rd_data[pwt_pkg::BIT_ENABLE]   = ctrl_ff.enable;
        nxt_rd_data[pwt_pkg::BIT_CLK_SEL]  = ctrl_ff.clk_sel;
        nxt_rd_data[pwt_pkg::BIT_FLAG]     = wake_flag_ff;
        nxt_rd_data[pwt_pkg::BIT_ACK]      = 1'b0;
        nxt_rd_data[pwt_pkg::BIT_IRQ_EN]   = ctrl_ff.irq_en;
        nxt_rd_data[pwt_pkg::BIT_STOP_RUN] = ctrl_ff.stop_run;
      end
      pwt_pkg::OFS_PRESCALE: begin
        nxt_rd_data[pwt_pkg::PRESCALE_LSB +: pwt_pkg::PRESCALE_W] = ctrl_ff.prescale;
      end
      pwt_pkg::OFS_MODULO: begin
        nxt_rd_data = ctrl_ff.modulo;
      end
      default: begin
        nxt_rd_data = pwt_pkg::RST_RDATA;
      end
    endcase
  end

  // Read data stand for exactly one cycle after the read strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= pwt_pkg::RST_RDATA;
    end else if (req.rd) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= pwt_pkg::RST_RDATA;
    end
  end

endmodule // pwt_timer

// ==== verification/pwt_timer_properties.sv ====
// Concurrent checks on the ports of the periodic wakeup timer.
`timescale 1ns/100ps
module pwt_timer_properties (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic [pwt_pkg::ADDR_W-1:0] addr,
  input wire logic [pwt_pkg::DATA_W-1:0] wr_data,
  input wire logic                       break_state,
  input wire logic                       break_clear_enable,
  input wire logic                       vector_fetch,
  input wire logic [pwt_pkg::DATA_W-1:0] rd_data_ff,
  input wire logic                       wake_irq_request_ff,
  input wire logic                       wake_flag_ff
);
  logic       en_ff;
  logic       ie_ff;
  logic [7:0] mod_ff;
  logic [2:0] idle_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow copies of the enable, interrupt enable and locked modulo fields.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_ff  <= 1'b0;
      ie_ff  <= 1'b0;
      mod_ff <= 8'h00;
    end else if (wr_en && addr == pwt_pkg::OFS_STATUS_CONTROL) begin
      en_ff <= wr_data[pwt_pkg::BIT_ENABLE];
      ie_ff <= wr_data[pwt_pkg::BIT_IRQ_EN];
    end else if (wr_en && addr == pwt_pkg::OFS_MODULO && !en_ff) begin
      mod_ff <= wr_data;
    end
  end

  // Cycles since the module was last enabled, saturating at seven.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) idle_ff <= 3'h7;
    else if (en_ff) idle_ff <= 3'h0;
    else if (idle_ff != 3'h7) idle_ff <= idle_ff + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_irq_equals_flag: assert property (wake_irq_request_ff == (wake_flag_ff && ie_ff))
    else $error("interrupt request differs from flag and enable");
  a_flag_fall_cause: assert property ($fell(wake_flag_ff) |->
    $past(vector_fetch) || ($past(wr_en) && $past(addr) == 2'h0 && $past(wr_data[3])))
    else $error("flag cleared without acknowledge or vector fetch");
  a_break_keeps_flag: assert property ($fell(wake_flag_ff) |->
    !$past(break_state) || $past(break_clear_enable))
    else $error("flag cleared during protected break");
  a_flag_needs_enable: assert property ($rose(wake_flag_ff) |-> idle_ff < 3'h4)
    else $error("flag set while module disabled");
  a_read_data_pulse: assert property (!$past(rd_en) |-> rd_data_ff == 8'h00)
    else $error("read data outside the read answer cycle");
  a_status_readback: assert property ($past(rd_en) && $past(addr) == 2'h0 |->
    !rd_data_ff[3] && rd_data_ff[2] == $past(wake_flag_ff))
    else $error("status read shows wrong flag or acknowledge bit");
  a_modulo_locked: assert property ($past(rd_en) && $past(addr) == 2'h2 |->
    rd_data_ff == $past(mod_ff))
    else $error("modulo read differs from last unlocked write");
  a_unmapped_zero: assert property ($past(rd_en) && $past(addr) == 2'h3 |-> rd_data_ff == 8'h00)
    else $error("unmapped read not zero");
  a_reset_clears: assert property (!$past(resetn) |-> !wake_flag_ff && !wake_irq_request_ff)
    else $error("flag or request set right after reset");

  c_irq_raised: cover property ($rose(wake_irq_request_ff));
  c_break_clear: cover property ($fell(wake_flag_ff) && $past(break_state));
  c_modulo_read: cover property ($past(rd_en) && $past(addr) == 2'h2);
endmodule // pwt_timer_properties

// ==== verification/pwt_sys_model.sv ====
// Model of the clock sources and interrupt logic around the periodic wakeup timer.
`timescale 1ns/100ps
module pwt_sys_model #(
  parameter int RC_DIV   = 16,
  parameter int FAST_DIV = 2
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic auto_fetch,
  input  wire logic irq,
  output logic      rc_osc_tick,
  output logic      fast_bus_tick,
  output logic      vector_fetch
);
  int rc_cnt;
  int fast_cnt;

  // Both source clocks run free, the fast one in stop mode too.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rc_cnt        <= 0;
      fast_cnt      <= 0;
      rc_osc_tick   <= 1'b0;
      fast_bus_tick <= 1'b0;
    end else begin
      rc_cnt        <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
      fast_cnt      <= (fast_cnt == FAST_DIV - 1) ? 0 : fast_cnt + 1;
      rc_osc_tick   <= (rc_cnt == RC_DIV - 1);
      fast_bus_tick <= (fast_cnt == FAST_DIV - 1);
    end
  end

  // The core takes a pending request by fetching its vector once.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) vector_fetch <= 1'b0;
    else vector_fetch <= auto_fetch && irq && !vector_fetch;
  end
endmodule // pwt_sys_model

// ==== verification/tb_pwt_timer.sv ====
// Self-checking bench of the periodic wakeup timer.
`timescale 1ns/100ps
module tb_pwt_timer;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wr_data = 8'h00;
  logic       stop_mode = 1'b0;
  logic       break_state = 1'b0;
  logic       break_clear_enable = 1'b0;
  logic       auto_fetch = 1'b0;
  logic       rc_osc_tick, fast_bus_tick, vector_fetch, wake_irq_request_ff, wake_flag_ff;
  logic [7:0] rd_data_ff;
  int         failures = 0;
  int         n_checks = 0;
  int         cyc = 0;

  pwt_timer pwt_timer_inst (.clk(clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rc_osc_tick(rc_osc_tick), .fast_bus_tick(fast_bus_tick),
    .stop_mode(stop_mode), .break_state(break_state), .break_clear_enable(break_clear_enable),
    .vector_fetch(vector_fetch), .rd_data_ff(rd_data_ff),
    .wake_irq_request_ff(wake_irq_request_ff), .wake_flag_ff(wake_flag_ff));
  pwt_sys_model #(.RC_DIV(16), .FAST_DIV(2)) pwt_sys_model_inst (.clk(clk), .resetn(resetn),
    .auto_fetch(auto_fetch), .irq(wake_irq_request_ff), .rc_osc_tick(rc_osc_tick),
    .fast_bus_tick(fast_bus_tick), .vector_fetch(vector_fetch));

  // Clock of 100 ns period and a cycle counter that cuts a hang short.
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr_en, addr, wr_data} <= {1'b1, a, d};
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    {rd_en, addr} <= {1'b1, a};
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data_ff;
  endtask

  // Waits for the flag to drop and then rise again; returns the cycle of the rise.
  task automatic wait_rise(output int at);
    int n;
    n = 0;
    while (wake_flag_ff === 1'b1 && n < 40000) begin @(posedge clk); #1; n++; end
    while (wake_flag_ff !== 1'b1 && n < 40000) begin @(posedge clk); #1; n++; end
    at = cyc;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), d);
      chk(d, 8'h00);
    end
  endtask

  // Programs while disabled, measures the flag period, then tries locked writes.
  task automatic measure(input logic sel, input logic [3:0] code, input logic [7:0] mod,
                         input int exp);
    int         t1, t2;
    logic [7:0] d;
    wr(2'h0, 8'h00);
    wr(2'h1, {4'h0, code});
    wr(2'h2, mod);
    wr(2'h0, {6'h04, sel, 1'b1});
    auto_fetch <= 1'b1;
    wait_rise(t1);
    wait_rise(t2);
    chk(16'(t2 - t1), 16'(exp));
    wr(2'h2, 8'h55);
    wr(2'h1, 8'h0A);
    wr(2'h0, {6'h04, ~sel, 1'b1});
    rd(2'h2, d);
    chk(d, mod);
    rd(2'h1, d);
    chk(d, {4'h0, code});
    rd(2'h0, d);
    chk(d & 8'hFB, {6'h04, sel, 1'b1});
  endtask

  task automatic t_stop();
    int t;
    auto_fetch <= 1'b0;
    wr(2'h0, 8'h00);
    wr(2'h0, 8'h08);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h04);
    stop_mode <= 1'b1;
    wr(2'h0, 8'h13);
    repeat (40) @(posedge clk);
    #1 chk(16'(wake_flag_ff), 16'h0000);
    wr(2'h0, 8'h33);
    wait_rise(t);
    chk(16'(wake_irq_request_ff), 16'h0001);
    stop_mode <= 1'b0;
  endtask

  task automatic t_break();
    logic [7:0] d;
    wr(2'h0, 8'h10);
    chk(16'(wake_irq_request_ff), 16'h0001);
    wr(2'h0, 8'h00);
    chk(16'(wake_irq_request_ff), 16'h0000);
    rd(2'h0, d);
    chk(d, 8'h04);
    break_state <= 1'b1;
    wr(2'h0, 8'h08);
    chk(16'(wake_flag_ff), 16'h0001);
    break_clear_enable <= 1'b1;
    wr(2'h0, 8'h08);
    break_state <= 1'b0;
    @(posedge clk);
    #1 chk(16'(wake_flag_ff), 16'h0000);
  endtask

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    measure(1'b1, 4'h1, 8'h03, 12);
    measure(1'b0, 4'h1, 8'h03, 96);
    measure(1'b1, 4'h5, 8'hFF, 16320);
    t_stop();
    t_break();
    give_verdict();
  end
endmodule // tb_pwt_timer

bind pwt_timer pwt_timer_properties pwt_timer_properties_inst (.clk, .resetn, .wr_en, .rd_en,
  .addr, .wr_data, .break_state, .break_clear_enable, .vector_fetch, .rd_data_ff,
  .wake_irq_request_ff, .wake_flag_ff);
